// [core/hbs_pkg.sv]
// Package for the holding brake sequencer: timing, widths, states.
// Assumes a single 10 MHz core clock; delays are set in ms and s.
// Summary of operation
// R1: Dedicated output releases brake on enable
// R2: Speed setpoint forced zero during run delay
// R3: Setpoints and starts ignored until run delay ends
// R4: Torque mode bypasses run and stop delays; code still applies the run delay after an auto-brake restart, and the stop delay on a disable within it
// R5: Disable first ramps speed setpoint to zero
// R6: Near-zero speed engages brake, starts stop delay
// R7: Stage stays active holding position during stop delay
// R8: Stage switched off after stop delay expires
// R9: Run and stop delays in ms, default zero
// R10: Idle time elapsed engages brake, stage off
// R11: Idle time set in seconds, default one
// R12: Drive state stays enabled during automatic brake
// R13: New positioning start re-activates stage itself
// R14: Zero-speed threshold configurable; zero delay no wait
package hbs_pkg;
  // Clock rate and derived tick periods
  localparam int CLK_HZ        = 10_000_000;
  localparam int MS_PER_S      = 1000;
  localparam int TICK_MS       = 1;
  localparam int CYC_PER_MS    = CLK_HZ / MS_PER_S * TICK_MS;
  localparam int TICK_W        = 14;
  // Setting widths
  localparam int DLY_W         = 16;
  localparam int IDLE_W        = 8;
  localparam int SPD_W         = 16;
  // Reset defaults of settings
  localparam logic [DLY_W-1:0]  RUN_DLY_RST  = 16'h0000;
  localparam logic [DLY_W-1:0]  STOP_DLY_RST = 16'h0000;
  localparam logic [IDLE_W-1:0] IDLE_S_RST   = 8'h01;
  // Sequencer states, one-hot
  typedef enum logic [5:0] {
    HBS_OFF   = 6'h01,
    HBS_RUNDL = 6'h02,
    HBS_RUN   = 6'h04,
    HBS_RAMP  = 6'h08,
    HBS_STOPD = 6'h10,
    HBS_AUTO  = 6'h20
  } hbs_state_e;
endpackage

// [core/hbs_tick.sv]
// Millisecond tick divider for the brake sequencer.
// Assumes one core clock; emits a one-cycle enable every millisecond.
`timescale 1ns/1ps
module hbs_tick
  import hbs_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Divider control and output
  input  wire logic clr,
  output logic      ms_tick
);
  typedef struct packed {
    logic [TICK_W-1:0] cnt;   // Cycle counter
    logic              tick;  // Registered tick
  } hbs_tick_s;

  hbs_tick_s st;
  hbs_tick_s next_st;

  // Count cycles, restart on clear
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (clr) begin
      next_st.cnt = '0;
    end else if (st.cnt == TICK_W'(CYC_PER_MS - 1)) begin
      next_st.cnt  = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 1'b1;
    end
  end

  // Register state
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign ms_tick = st.tick;
endmodule // hbs_tick

// [core/hbs_sequencer.sv]
// Holding brake sequencer: enable/disable brake timing, auto brake.
// Assumes synchronous inputs on core_clk; settings are static ports.
// Brake output high releases the brake; low lets the spring engage it.
// All delays count a shared 1 ms tick that restarts on each state change.
`timescale 1ns/1ps
module hbs_sequencer
  import hbs_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  // Drive control
  input  wire logic              drive_enable,
  input  wire logic              torque_mode,
  input  wire logic              auto_brake_en,
  // Motion control side
  input  wire logic signed [SPD_W-1:0] speed_set_in,
  input  wire logic              pos_start_in,
  input  wire logic signed [SPD_W-1:0] speed_act,
  input  wire logic              axis_moving,
  // Settings
  input  wire logic [DLY_W-1:0]  run_delay_ms,
  input  wire logic [DLY_W-1:0]  stop_delay_ms,
  input  wire logic [IDLE_W-1:0] idle_time_s,
  input  wire logic [SPD_W-1:0]  zero_speed_thr,
  // Outputs
  output logic signed [SPD_W-1:0] speed_set_out,
  output logic                   pos_start_out,
  output logic                   hold_position,
  output logic                   stage_on,
  output logic                   brake_release,
  output logic                   drive_enabled
);
  // Whole sequencer state in one register; outputs are fields of it,
  // so every output comes straight from a flip-flop and never glitches.
  // The ms counter is shared by run delay and stop delay.
  typedef struct packed {
    hbs_state_e        state;     // Sequencer state
    logic [DLY_W-1:0]  ms_cnt;    // Elapsed ms in delay
    logic [DLY_W-1:0]  idle_ms;   // Elapsed ms within idle second
    logic [IDLE_W-1:0] idle_s;    // Elapsed idle seconds
    logic signed [SPD_W-1:0] spd; // Setpoint output
    logic              start;     // Start pulse output
    logic              hold;      // Position hold output
    logic              stage;     // Output stage on
    logic              brk;       // Brake released
    logic              en_rep;    // Reported enabled state
  } hbs_seq_s;

  hbs_seq_s st;
  hbs_seq_s next_st;
  logic     ms_tick;   // One-ms enable
  logic     tick_clr;  // Restart divider at delay start

  // Absolute value compare against zero-speed threshold
  // Most negative speed yields 16'h8000, so it never wraps to zero
  function automatic logic is_still(input logic signed [SPD_W-1:0] v,
                                    input logic [SPD_W-1:0] thr);
    logic [SPD_W-1:0] mag;
    mag = v[SPD_W-1] ? SPD_W'(-v) : v;
    return mag <= thr;
  endfunction

  // Delay done test; zero setting means no wait
  // Counter saturates, so the compare never misses a long setting
  function automatic logic dly_done(input logic [DLY_W-1:0] cnt,
                                    input logic [DLY_W-1:0] lim);
    return cnt >= lim;
  endfunction

  // Millisecond enable shared by all delay and idle timers
  hbs_tick u_tick (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clr      (tick_clr),
    .ms_tick  (ms_tick)
  );

  // Divider restarts whenever a timed state is entered
  assign tick_clr = (next_st.state != st.state);

  // Next-state and output logic
  always_comb begin
    next_st = st;
    next_st.start = 1'b0;
    // Count elapsed ms; hold at all ones instead of wrapping
    if (ms_tick && st.ms_cnt != '1) begin
      next_st.ms_cnt = st.ms_cnt + 1'b1;
    end
    case (st.state)
      // Idle: stage off, brake engaged, nothing reported enabled.
      // An enable releases the brake at once; torque mode skips the
      // run delay because torque setpoints need no standstill.
      HBS_OFF: begin
        next_st.stage  = 1'b0;
        next_st.brk    = 1'b0;
        next_st.hold   = 1'b0;
        next_st.en_rep = 1'b0;
        next_st.spd    = '0;
        if (drive_enable) begin
          next_st.stage  = 1'b1;
          next_st.brk    = 1'b1;                        // R1
          next_st.en_rep = 1'b1;
          next_st.ms_cnt = '0;
          next_st.state  = torque_mode ? HBS_RUN : HBS_RUNDL; // R4
        end
      end
      // Run delay: stage on, brake lifting, setpoint pinned at zero.
      // Starts are dropped here, not queued, so a stale start never
      // launches a move after the delay.
      HBS_RUNDL: begin
        next_st.spd = '0;                                // R2
        if (!drive_enable) begin
          next_st.state = HBS_RAMP;
        end else if (dly_done(st.ms_cnt, run_delay_ms)) begin // R9 R14
          next_st.state = HBS_RUN;                       // R3
        end
      end
      // Running: setpoints and starts pass with one cycle of latency.
      // Disable ramps to zero first; in torque mode it ends at once.
      // The idle timer counts whole seconds of standstill on ms ticks
      // while the automatic brake is allowed.
      HBS_RUN: begin
        next_st.spd   = speed_set_in;
        next_st.start = pos_start_in;
        next_st.hold  = 1'b0;
        if (!drive_enable) begin
          next_st.spd   = '0;                            // R5
          next_st.state = torque_mode ? HBS_OFF : HBS_RAMP; // R4
        end else if (auto_brake_en && axis_moving) begin
          // Motion while the automatic brake is allowed restarts the idle timer
          next_st.idle_ms = '0;
          next_st.idle_s  = '0;
        end else if (auto_brake_en && ms_tick) begin
          if (st.idle_ms == DLY_W'(MS_PER_S - 1)) begin
            next_st.idle_ms = '0;
            next_st.idle_s  = st.idle_s + 1'b1;
          end else begin
            next_st.idle_ms = st.idle_ms + 1'b1;
          end
        end
        // Automatic brake: only when still, with no start pending, so
        // a start in the same cycle wins and the move is not lost.
        // Setpoint drops to zero as the stage goes off.
        if (drive_enable && auto_brake_en && !pos_start_in
            && !axis_moving
            && st.idle_s >= idle_time_s) begin           // R11
          next_st.brk   = 1'b0;                          // R10
          next_st.stage = 1'b0;
          next_st.spd   = '0;
          next_st.state = HBS_AUTO;                      // R12
        end
      end
      // Ramp: setpoint zero, stage kept on until the measured speed
      // is inside the standstill band; then the brake engages and the
      // stop delay starts from a fresh ms count.
      HBS_RAMP: begin
        next_st.spd = '0;                                // R5
        if (is_still(speed_act, zero_speed_thr)) begin  // R14
          next_st.brk    = 1'b0;                         // R6
          next_st.hold   = 1'b1;
          next_st.ms_cnt = '0;
          next_st.state  = HBS_STOPD;
        end
      end
      // Stop delay: brake engaged, stage still on and holding the
      // present position while the brake builds torque; the stage
      // goes off only once the delay has run out.
      HBS_STOPD: begin
        next_st.spd  = '0;
        next_st.hold = 1'b1;                             // R7
        if (dly_done(st.ms_cnt, stop_delay_ms)) begin    // R9 R14
          next_st.stage = 1'b0;                          // R8
          next_st.hold  = 1'b0;
          next_st.state = HBS_OFF;
        end
      end
      // Automatic brake: stage off but the drive still reports enabled.
      // A start re-energises the stage and runs the run delay again;
      // a disable goes straight to idle as the brake is already on.
      HBS_AUTO: begin
        next_st.spd    = '0;
        next_st.en_rep = 1'b1;                           // R12
        if (!drive_enable) begin
          next_st.state = HBS_OFF;
        end else if (pos_start_in) begin
          next_st.stage   = 1'b1;                        // R13
          next_st.brk     = 1'b1;
          next_st.idle_ms = '0;
          next_st.idle_s  = '0;
          next_st.ms_cnt  = '0;
          next_st.state   = HBS_RUNDL;                   // R3
        end
      end
      // Illegal code recovers to idle
      default: begin
        next_st.state = HBS_OFF;
      end
    endcase
    // Idle timer only lives in RUN and AUTO; clear it everywhere else
    // so a later enable never inherits an old standstill count.
    if (st.state != HBS_RUN && st.state != HBS_AUTO) begin
      next_st.idle_ms = '0;
      next_st.idle_s  = '0;
    end
  end

  // Register state; reset lands in idle with brake engaged
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{state: HBS_OFF, default: '0};
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flip-flops
  assign speed_set_out = st.spd;
  assign pos_start_out = st.start;
  assign hold_position = st.hold;
  assign stage_on      = st.stage;
  assign brake_release = st.brk;                         // R1
  assign drive_enabled = st.en_rep;
endmodule // hbs_sequencer

// [tb/hbs_brake_model.sv]
// Behavioural holding brake hung on the dedicated brake output.
// Assumes brake_release is a registered level on core_clk.
`timescale 1ns/1ps
module hbs_brake_model (
  // Clock
  input  wire logic core_clk,
  // Brake output of the drive
  input  wire logic brake_release,
  // Mechanical state
  output logic      engaged
);
  // Spring applies brake unless the coil is fed; one cycle of lag
  always_ff @(posedge core_clk) begin
    engaged <= !brake_release;
  end
endmodule // hbs_brake_model

// [tb/hbs_sequencer_sva.sv]
// Checker for the brake sequencer, watching top-level ports only.
// Assumes one core_clk domain with async active-low rst_n.
`timescale 1ns/1ps
module hbs_sequencer_sva
  import hbs_pkg::*;
(
  // Clock, reset, inputs and setpoint output
  input wire logic core_clk, rst_n, drive_enable, torque_mode,
  input wire logic pos_start_in, auto_brake_en, axis_moving,
  input wire logic signed [SPD_W-1:0] speed_set_in, speed_set_out,
  // Outputs
  input wire logic pos_start_out, hold_position, stage_on,
  input wire logic brake_release, drive_enabled
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Enable from idle answers next cycle
  en_answer_a: assert property (drive_enable && !stage_on
    && !drive_enabled |=> brake_release && stage_on && drive_enabled)
    else $error("enable not answered");
  spd_gate_a: assert property (speed_set_out != 0 |-> stage_on
    && brake_release && !hold_position) else $error("setpoint leaked");
  pos_gate_a: assert property (pos_start_out |-> $past(pos_start_in)
    && brake_release) else $error("start leaked");
  // Torque setpoint passes with one cycle of latency once enabled
  torque_a: assert property ((torque_mode && drive_enable)[*4]
    |=> speed_set_out == $past(speed_set_in)) else $error("torque late");
  ramp_a: assert property (!drive_enable && stage_on && !torque_mode
    |=> speed_set_out == 0) else $error("no ramp to zero");
  engage_a: assert property ($rose(hold_position)
    |-> $fell(brake_release)) else $error("brake not engaged");
  hold_stage_a: assert property (hold_position
    |-> stage_on && !brake_release) else $error("stage dropped");
  stop_end_a: assert property ($fell(hold_position) && !drive_enable
    |-> !stage_on) else $error("stage left on");
  auto_state_a: assert property ($fell(stage_on) && auto_brake_en
    && drive_enable |-> drive_enabled) else $error("state lost");
  restart_a: assert property (pos_start_in && drive_enable
    && !stage_on && drive_enabled |=> stage_on && brake_release)
    else $error("no restart");
  // Setpoint held at zero for two cycles after the stage comes on
  run_zero_a: assert property ($rose(stage_on) && !torque_mode
    |-> speed_set_out == 0 ##1 speed_set_out == 0)
    else $error("setpoint during run delay");
  // Motion keeps the automatic brake away
  idle_move_a: assert property (auto_brake_en && axis_moving
    && drive_enable && stage_on && !hold_position |=> stage_on)
    else $error("brake while moving");
  // Main scenarios reached
  c_hold: cover property ($rose(hold_position));
  c_auto: cover property ($fell(stage_on) && drive_enabled);
  c_pass: cover property (pos_start_out);
endmodule // hbs_sequencer_sva
bind hbs_sequencer hbs_sequencer_sva hbs_sequencer_sva_i (
  .core_clk(core_clk), .rst_n(rst_n), .drive_enable(drive_enable),
  .torque_mode(torque_mode), .pos_start_in(pos_start_in),
  .auto_brake_en(auto_brake_en), .speed_set_in(speed_set_in),
  .axis_moving(axis_moving),
  .speed_set_out(speed_set_out), .pos_start_out(pos_start_out),
  .hold_position(hold_position), .stage_on(stage_on),
  .brake_release(brake_release), .drive_enabled(drive_enabled));

// [tb/hbs_sequencer_test.sv]
// Testbench for the brake sequencer with a brake model on its output.
// Assumes delays of 1 ms or 0 ms and idle times of 0 s or 1 s; the run stays short.
`timescale 1ns/1ps
module hbs_sequencer_test;
  import hbs_pkg::*;
  logic core_clk, rst_n, en, tq, ab, ps, mv, po, hp, st, br, de, eng;
  logic signed [SPD_W-1:0] si, sa, so;
  logic [DLY_W-1:0]  rd, sd;
  logic [IDLE_W-1:0] it;
  logic [SPD_W-1:0]  thr;
  int err_count, cmp_count, cyc, k;
  hbs_sequencer hbs_sequencer_i (.core_clk(core_clk), .rst_n(rst_n),
    .drive_enable(en), .torque_mode(tq), .auto_brake_en(ab),
    .speed_set_in(si), .pos_start_in(ps), .speed_act(sa),
    .axis_moving(mv), .run_delay_ms(rd), .stop_delay_ms(sd),
    .idle_time_s(it), .zero_speed_thr(thr), .speed_set_out(so),
    .pos_start_out(po), .hold_position(hp), .stage_on(st),
    .brake_release(br), .drive_enabled(de));
  hbs_brake_model hbs_brake_model_i (.core_clk(core_clk),
    .brake_release(br), .engaged(eng));
  // Clock, 100 ns period
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // Wait n edges; checks then run 1 ns later
  task w(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    #1 cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Hang guard
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      results;
    end
  end
  initial begin
    {rst_n, en, tq, ab, ps, mv} = '0;
    {err_count, cmp_count} = '0;
    si = 16'h0123; sa = 16'h0005; rd = 16'h0001; sd = 16'h0001;
    it = 8'h00;
    thr = 16'h0004;
    w(8); rst_n <= 1'b1;
    // Enable with 1 ms run delay, start held
    w(1); en <= 1'b1; ps <= 1'b1;
    w(2); chk(br, 1); chk(st, 1); chk(so, 0);
    w(2); chk(eng, 0);
    w(9986); chk(so, 0); chk(po, 0);
    w(20); chk(so, 16'h0123); chk(po, 1);
    // Disable while still turning, then at the threshold
    w(1); en <= 1'b0; ps <= 1'b0;
    w(3); chk(so, 0); chk(st, 1); chk(br, 1);
    w(1); sa <= 16'hfffc;
    w(3); chk(br, 0); chk(hp, 1); chk(st, 1); chk(eng, 1);
    w(9990); chk(st, 1);
    w(20); chk(st, 0); chk(hp, 0);
    // Torque mode ignores both delays
    w(1); tq <= 1'b1; en <= 1'b1;
    w(4); chk(so, 16'h0123);
    w(1); en <= 1'b0;
    w(3); chk(st, 0); chk(br, 0);
    // Zero delays, then automatic brake and restart
    w(1); tq <= 1'b0; rd <= '0; sd <= '0; en <= 1'b1;
    w(4); chk(so, 16'h0123);
    w(1); ab <= 1'b1; mv <= 1'b1; it <= 8'h01;
    w(4); chk(st, 1);
    w(1); mv <= 1'b0;
    w(4); chk(st, 1); chk(de, 1);
    w(1); it <= 8'h00;
    for (k = 0; k < 20000 && st !== 1'b0; k++) w(1);
    chk(st, 0); chk(br, 0); chk(de, 1);
    w(1); ps <= 1'b1;
    w(2); chk(st, 1); chk(br, 1);
    results;
  end
endmodule // hbs_sequencer_test
